// File: design/aiso_crc16.sv
`timescale 1ns/1ps
`include "aiso_regs.svh"
module aiso_crc16 #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] i_data,
	output logic      [15:0]  o_crc
);
	// bitwise msb-first shift; purely combinational, caller registers it
	always_comb begin
		logic [15:0] c;
		c = `AISO_CRC_INIT;
		for (int k = W - 1; k >= 0; k--) begin
			if (c[15] ^ i_data[k])
				c = {c[14:0], 1'b0} ^ `AISO_CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		o_crc = c;
	end
endmodule : aiso_crc16

// File: design/aiso_sync2.sv
`timescale 1ns/1ps
module aiso_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			meta   <= '1;
			o_sync <= '1;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule : aiso_sync2

// File: design/aiso_top.sv
`timescale 1ns/1ps
`include "aiso_regs.svh"
module aiso_top (
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_sclk,
	input  wire logic                 i_cs_n,
	input  wire logic                 i_mosi,
	input  wire logic                 i_sample_valid,
	input  wire aiso_pkg::aiso_sample_t i_current_sample,
	input  wire aiso_pkg::aiso_sample_t i_voltage_one_sample,
	input  wire aiso_pkg::aiso_sample_t i_voltage_two_sample,
	input  wire aiso_pkg::aiso_byte_t i_temperature_offset,
	output logic                      o_miso,
	output logic                      o_miso_oe_n,
	output logic                      o_clk_sample_ready_strobe,
	output logic                      o_dcdc_enable,
	output logic                      o_modulator_enable,
	output aiso_pkg::aiso_byte_t      o_emission_control
);
	import aiso_pkg::*;

	localparam int HOLD = `AISO_RST_HOLD_CYC;

	function automatic logic [23:0] just8(input logic [7:0] v);
		just8 = {v, 16'h0000};
	endfunction : just8

	function automatic logic [23:0] just16(input logic [15:0] v);
		just16 = {v, 8'h00};
	endfunction : just16

	// pin sampling and edge finding
	logic [2:0]   pins_s;
	logic         sclk_d;
	logic         sclk_rise;
	logic         sclk_fall;
	logic         cs_n_s;
	logic         mosi_s;

	aiso_sync2 #(.W(3)) u_pin_sync (
		.i_clk   (i_clk),
		.i_resetn(i_resetn),
		.i_async ({i_sclk, i_cs_n, i_mosi}),
		.o_sync  (pins_s)
	);

	assign cs_n_s    = pins_s[1];
	assign mosi_s    = pins_s[0];
	assign sclk_rise = pins_s[2] & ~sclk_d;
	assign sclk_fall = ~pins_s[2] & sclk_d;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			sclk_d <= 1'b1;
		else
			sclk_d <= pins_s[2];
	end

	// register state
	aiso_state_e  state;
	logic [15:0]  timer;
	aiso_byte_t   device_setup;
	aiso_byte_t   emission_control;
	logic         locked;
	logic [11:0]  sync_counter;
	logic [11:0]  sync_counter_capture;
	aiso_sample_t current_sample;
	aiso_sample_t voltage_one_sample;
	aiso_sample_t voltage_two_sample;
	logic [15:0]  sample_checksum;
	logic [15:0]  setup_checksum;
	logic [15:0]  next_sample_crc;
	logic [15:0]  next_setup_crc;
	logic [6:0]   zero_cnt;
	logic [6:0]   sample_ready_strobe_cnt;
	logic         clk_div;

	// serial frame state
	logic [4:0]   bit_cnt;
	logic [7:0]   rx_shift;
	logic [7:0]   next_rx;
	logic [4:0]   cmd_addr;
	logic         cmd_read;
	logic [23:0]  tx_shift;
	logic [23:0]  rd_word;
	logic         wr_pulse;
	logic         hw_event;
	logic         sw_event;
	logic         defaults_load;
	logic         wr_ok;

	assign next_rx  = {rx_shift[6:0], mosi_s};
	assign wr_pulse = sclk_rise && !cs_n_s && bit_cnt == 5'h0F && !cmd_read;
	// protection blocks everything except the key itself
	assign wr_ok    = wr_pulse && state == AISO_ST_RUN && (!locked || cmd_addr == `AISO_ADDR_KEY);
	// counted only while selected: a device whose chip select is high never sees the zeros
	assign hw_event = sclk_rise && !cs_n_s && !mosi_s
		&& zero_cnt == 7'(`AISO_HWRST_ZEROS - 1);
	assign sw_event = device_setup[`AISO_SETUP_SOFT_RESET_REQUEST];
	assign defaults_load = hw_event || sw_event;

	// frame: command byte {addr[4:0], read, 2'b00}, then data
	always_ff @(posedge i_clk) begin
		if (!i_resetn || cs_n_s)
			bit_cnt <= 5'h00;
		else if (sclk_rise && bit_cnt != 5'h1F)
			bit_cnt <= bit_cnt + 5'h01;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rx_shift <= 8'h00;
			cmd_addr <= 5'h00;
			cmd_read <= 1'b0;
		end else if (sclk_rise && !cs_n_s) begin
			rx_shift <= next_rx;
			if (bit_cnt == 5'h07) begin
				cmd_addr <= next_rx[7:3];
				cmd_read <= next_rx[2];
			end
		end
	end

	// sixty-four zero bits in one frame; anything else restarts the count
	always_ff @(posedge i_clk) begin
		if (!i_resetn || cs_n_s)
			zero_cnt <= 7'h00;
		else if (sclk_rise) begin
			if (mosi_s || hw_event)
				zero_cnt <= 7'h00;
			else
				zero_cnt <= zero_cnt + 7'h01;
		end
	end

	always_comb begin
		case (cmd_addr)
		`AISO_ADDR_CURRENT:   rd_word = current_sample;
		`AISO_ADDR_VOLT1:     rd_word = voltage_one_sample;
		`AISO_ADDR_VOLT2:     rd_word = voltage_two_sample;
		`AISO_ADDR_SMP_CRC:   rd_word = just16(sample_checksum);
		`AISO_ADDR_SET_CRC:   rd_word = just16(setup_checksum);
		`AISO_ADDR_CAPTURE:   rd_word = just16({4'h0, sync_counter_capture});
		`AISO_ADDR_SETUP:     rd_word = just8(device_setup);
		`AISO_ADDR_PRIMARY:   rd_word = just8({5'h00, locked, 1'b0,
			state != AISO_ST_RUN});
		`AISO_ADDR_CNT_LOW:   rd_word = just8(sync_counter[7:0]);
		`AISO_ADDR_CNT_HIGH:  rd_word = just8({4'h0, sync_counter[11:8]});
		`AISO_ADDR_EMI:       rd_word = just8(emission_control);
		`AISO_ADDR_SECONDARY: rd_word = just8({5'h00, `AISO_VERSION});
		`AISO_ADDR_TEMP:      rd_word = just8(i_temperature_offset);
		// reserved, key and sync command all read as zero
		default:              rd_word = 24'h000000;
		endcase
	end

	// shift out on falling sclk so the host samples on the rising one
	always_ff @(posedge i_clk) begin
		if (!i_resetn || cs_n_s) begin
			tx_shift    <= 24'h000000;
			o_miso      <= 1'b0;
			o_miso_oe_n <= 1'b1;
		end else begin
			o_miso_oe_n <= 1'b0;
			if (sclk_fall && cmd_read && bit_cnt == 5'h08) begin
				o_miso   <= rd_word[23];
				tx_shift <= {rd_word[22:0], 1'b0};
			end else if (sclk_fall && cmd_read && bit_cnt > 5'h08) begin
				o_miso   <= tx_shift[23];
				tx_shift <= {tx_shift[22:0], 1'b0};
			end
		end
	end

	// power-on counts as a hardware reset
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state <= AISO_ST_HWRST;
			timer <= 16'h0000;
		end else if (hw_event) begin
			state <= AISO_ST_HWRST;
			timer <= 16'h0000;
		end else if (sw_event) begin
			state <= AISO_ST_SOFT_RESET_REQUEST;
			timer <= 16'h0000;
		end else begin
			case (state)
			AISO_ST_RUN: timer <= 16'h0000;
			AISO_ST_HWRST, AISO_ST_SOFT_RESET_REQUEST: begin
				if (timer == 16'(HOLD - 1))
					state <= AISO_ST_RUN;
				else
					timer <= timer + 16'h0001;
			end
			default: state <= AISO_ST_HWRST;
			endcase
		end
	end

	// configuration registers; soft reset bit lives one cycle then defaults wipe it
	always_ff @(posedge i_clk) begin
		if (!i_resetn || defaults_load) begin
			device_setup     <= `AISO_SETUP_RST;
			emission_control <= `AISO_EMI_RST;
		end else if (wr_ok && cmd_addr == `AISO_ADDR_SETUP) begin
			device_setup <= next_rx;
		end else if (wr_ok && cmd_addr == `AISO_ADDR_EMI) begin
			emission_control <= next_rx;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn || defaults_load)
			locked <= 1'b0;
		else if (wr_ok && cmd_addr == `AISO_ADDR_KEY) begin
			if (next_rx == `AISO_KEY_LOCK)
				locked <= 1'b1;
			else if (next_rx == `AISO_KEY_UNLOCK)
				locked <= 1'b0;
		end
	end

	// free-running counter; sync command clears or snapshots it
	always_ff @(posedge i_clk) begin
		if (!i_resetn || defaults_load) begin
			sync_counter         <= 12'h000;
			sync_counter_capture <= 12'h000;
		end else if (wr_ok && cmd_addr == `AISO_ADDR_CNT_LOW) begin
			sync_counter[7:0] <= next_rx;
		end else if (wr_ok && cmd_addr == `AISO_ADDR_CNT_HIGH) begin
			sync_counter[11:8] <= next_rx[3:0];
		end else if (wr_ok && cmd_addr == `AISO_ADDR_SYNC && next_rx == `AISO_SYNC_CLEAR) begin
			sync_counter <= 12'h000;
		end else begin
			sync_counter <= sync_counter + 12'h001;
			if (wr_ok && cmd_addr == `AISO_ADDR_SYNC && next_rx == `AISO_SYNC_COMMAND)
				sync_counter_capture <= sync_counter;
		end
	end

	// samples only load from the converter; bus writes never reach them
	always_ff @(posedge i_clk) begin
		if (!i_resetn || defaults_load) begin
			current_sample     <= 24'h000000;
			voltage_one_sample <= 24'h000000;
			voltage_two_sample <= 24'h000000;
		end else if (i_sample_valid && state == AISO_ST_RUN
			&& !device_setup[`AISO_SETUP_PWRDWN]) begin
			current_sample     <= i_current_sample;
			voltage_one_sample <= i_voltage_one_sample;
			voltage_two_sample <= i_voltage_two_sample;
		end
	end

	aiso_crc16 #(.W(72)) u_sample_crc (
		.i_data({current_sample, voltage_one_sample, voltage_two_sample}),
		.o_crc (next_sample_crc)
	);

	aiso_crc16 #(.W(32)) u_setup_crc (
		.i_data({device_setup, emission_control, 4'h0, sync_counter[11:8], locked, 7'h00}),
		.o_crc (next_setup_crc)
	);

	// registered to keep the long xor chains off the read path
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sample_checksum <= 16'h0000;
			setup_checksum  <= 16'h0000;
		end else begin
			sample_checksum <= next_sample_crc;
			setup_checksum  <= next_setup_crc;
		end
	end

	// ready strobe, low for a fixed count after each new sample
	always_ff @(posedge i_clk) begin
		if (!i_resetn || defaults_load)
			sample_ready_strobe_cnt <= 7'h00;
		else if (i_sample_valid && state == AISO_ST_RUN
			&& !device_setup[`AISO_SETUP_PWRDWN])
			sample_ready_strobe_cnt <= 7'(`AISO_SAMPLE_READY_STROBE_CYC);
		else if (sample_ready_strobe_cnt != 7'h00)
			sample_ready_strobe_cnt <= sample_ready_strobe_cnt - 7'h01;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			clk_div      <= 1'b0;
			o_clk_sample_ready_strobe <= 1'b1;
		end else begin
			clk_div <= ~clk_div;
			if (device_setup[`AISO_SETUP_CLOCK_OUTPUT])
				o_clk_sample_ready_strobe <= clk_div;
			else
				o_clk_sample_ready_strobe <= (sample_ready_strobe_cnt == 7'h00);
		end
	end

	// converter stays up through soft reset, drops in hardware reset
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_dcdc_enable      <= 1'b0;
			o_modulator_enable <= 1'b0;
			o_emission_control <= `AISO_EMI_RST;
		end else begin
			o_dcdc_enable      <= state != AISO_ST_HWRST
				&& !device_setup[`AISO_SETUP_PWRDWN];
			o_modulator_enable <= state != AISO_ST_HWRST
				&& !device_setup[`AISO_SETUP_PWRDWN];
			o_emission_control <= emission_control;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	hwrst_dcdc_off_a: assert property (
		hw_event |=> ##1 (!o_dcdc_enable && state == AISO_ST_HWRST))
		else $error("converter not stopped by hardware reset");

	zero_frame_rst_a: assert property (
		(sclk_rise && !cs_n_s && !mosi_s && zero_cnt == 7'd63) |=> device_setup == 8'h00
			&& state == AISO_ST_HWRST)
		else $error("zero pattern did not reset");

	soft_reset_request_self_clear_a: assert property (
		sw_event |=> (!device_setup[`AISO_SETUP_SOFT_RESET_REQUEST] && state == AISO_ST_SOFT_RESET_REQUEST))
		else $error("soft reset bit did not clear after one cycle");

	soft_reset_request_dcdc_on_a: assert property (
		(state == AISO_ST_SOFT_RESET_REQUEST && !hw_event) |=> o_dcdc_enable)
		else $error("converter dropped during soft reset");

	reset_end_a: assert property (
		(state != AISO_ST_RUN && timer == 16'h0000 && !hw_event && !sw_event)
			|-> ##[HOLD:HOLD] (state == AISO_ST_RUN))
		else $error("reset period length wrong");

	pwrdwn_stop_a: assert property (
		device_setup[`AISO_SETUP_PWRDWN] |=> (!o_dcdc_enable && !o_modulator_enable))
		else $error("power-down did not stop converter");

	clock_output_quiet_a: assert property (
		(!device_setup[`AISO_SETUP_CLOCK_OUTPUT] && sample_ready_strobe_cnt == 7'h00) |=> o_clk_sample_ready_strobe)
		else $error("clock output active while disabled");

	lock_block_a: assert property (
		(wr_pulse && locked && cmd_addr == `AISO_ADDR_SETUP && !defaults_load)
			|=> $stable(device_setup))
		else $error("locked setup register was written");

	ro_write_a: assert property (
		(wr_pulse && cmd_addr == `AISO_ADDR_CURRENT && !i_sample_valid && !defaults_load)
			|=> $stable(current_sample))
		else $error("read-only sample changed on write");

	rsv_read_a: assert property (
		(sclk_fall && cmd_read && bit_cnt == 5'h08 && !cs_n_s
			&& (cmd_addr == `AISO_ADDR_RSV_WIDE || cmd_addr == `AISO_ADDR_RSV_HALF))
			|=> !o_miso)
		else $error("reserved location read non-zero");
endmodule : aiso_top

// File: include/aiso_pkg.sv
package aiso_pkg;
	typedef logic [7:0] aiso_byte_t;
	typedef logic [23:0] aiso_sample_t;
	typedef enum logic [2:0] {
		AISO_ST_RUN   = 3'b001,
		AISO_ST_HWRST = 3'b010,
		AISO_ST_SOFT_RESET_REQUEST = 3'b100
	} aiso_state_e;
endpackage : aiso_pkg

// File: include/aiso_regs.svh
`ifndef AISO_REGS_SVH
`define AISO_REGS_SVH
`define AISO_ADDR_CURRENT   5'h00
`define AISO_ADDR_VOLT1     5'h01
`define AISO_ADDR_VOLT2     5'h02
`define AISO_ADDR_RSV_WIDE  5'h03
`define AISO_ADDR_SMP_CRC   5'h04
`define AISO_ADDR_SET_CRC   5'h05
`define AISO_ADDR_RSV_HALF  5'h06
`define AISO_ADDR_CAPTURE   5'h07
`define AISO_ADDR_SETUP     5'h08
`define AISO_ADDR_PRIMARY   5'h09
`define AISO_ADDR_KEY       5'h0A
`define AISO_ADDR_SYNC      5'h0B
`define AISO_ADDR_CNT_LOW   5'h0C
`define AISO_ADDR_CNT_HIGH  5'h0D
`define AISO_ADDR_EMI       5'h0E
`define AISO_ADDR_SECONDARY 5'h0F
`define AISO_ADDR_NOWRITE_A 5'h10
`define AISO_ADDR_NOWRITE_B 5'h11
`define AISO_ADDR_TEMP      5'h18
`define AISO_SETUP_CLOCK_OUTPUT   0
`define AISO_SETUP_PWRDWN   2
`define AISO_SETUP_SOFT_RESET_REQUEST    6
`define AISO_FLAG_RESETON   0
`define AISO_FLAG_PROT      2
`define AISO_SETUP_RST      8'h00
`define AISO_EMI_RST        8'hFF
`define AISO_KEY_UNLOCK     8'h9C
`define AISO_KEY_LOCK       8'hCA
`define AISO_SYNC_CLEAR     8'h01
`define AISO_SYNC_COMMAND      8'h02
`define AISO_VERSION        3'h1
`define AISO_CRC_INIT       16'hFFFF
`define AISO_CRC_POLY       16'h1021
`define AISO_CLK_NS         40
`define AISO_RST_HOLD_NS    2000
`define AISO_RST_HOLD_CYC   ((`AISO_RST_HOLD_NS + `AISO_CLK_NS - 1) / `AISO_CLK_NS)
`define AISO_HWRST_ZEROS    64
`define AISO_SAMPLE_READY_STROBE_CYC     64
`endif

// File: sim/aiso_host_model.sv
`timescale 1ns/1ps
module aiso_host_model #(
	parameter int HALF_NS = 160
) (
	input  wire logic i_miso,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_mosi
);
	// serial clock rests low between frames, as mode 0 asks
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b1;
	end

	// bit set on the falling side, both ends take it on the rising edge
	task automatic shift_bit(input logic b, output logic r);
		o_mosi = b;
		#(HALF_NS);
		o_sclk = 1'b1;
		r = i_miso;
		#(HALF_NS);
		o_sclk = 1'b0;
	endtask : shift_bit

	task automatic frame(input logic [4:0] addr, input logic rd, input logic [23:0] wd,
			input int nb, output logic [23:0] q);
		logic [7:0] hdr;
		logic r;
		hdr = {addr, rd, 2'b00};
		q = '0;
		// odd offset keeps the link out of phase with the system clock
		#13;
		o_cs_n = 1'b0;
		#(HALF_NS);
		for (int i = 7; i >= 0; i--) shift_bit(hdr[i], r);
		for (int i = nb - 1; i >= 0; i--) begin
			shift_bit(rd ? 1'b0 : wd[i], r);
			q[i] = r;
		end
		o_cs_n = 1'b1;
		// deselected: the data line must not keep looking valid
		o_mosi = ~o_mosi;
		#(3 * HALF_NS);
	endtask : frame

	task automatic hw_reset();
		logic r;
		#13;
		o_cs_n = 1'b0;
		#(HALF_NS);
		repeat (64) shift_bit(1'b0, r);
		o_cs_n = 1'b1;
		o_mosi = 1'b1;
		#(3 * HALF_NS);
	endtask : hw_reset
endmodule : aiso_host_model

// File: sim/aiso_top_tb.sv
`timescale 1ns/1ps
`include "aiso_regs.svh"
`define CHK(a, e) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("BAD t=%0t got %0h exp %0h", $time, a, e); \
	end \
end
module aiso_top_tb;
	import aiso_pkg::*;
	logic         i_clk;
	logic         i_resetn;
	logic         i_sclk;
	logic         i_cs_n;
	logic         i_mosi;
	logic         i_sample_valid;
	aiso_sample_t i_current_sample;
	aiso_sample_t i_voltage_one_sample;
	aiso_sample_t i_voltage_two_sample;
	aiso_byte_t   i_temperature_offset;
	logic         o_miso;
	logic         o_miso_oe_n;
	logic         o_clk_sample_ready_strobe;
	logic         o_dcdc_enable;
	logic         o_modulator_enable;
	aiso_byte_t   o_emission_control;
	int           failures;
	int           total_checks;
	logic [23:0]  q;
	logic         watch_dcdc;
	logic         dcdc_drop;

	aiso_top DUT (.i_clk, .i_resetn, .i_sclk, .i_cs_n, .i_mosi, .i_sample_valid,
		.i_current_sample, .i_voltage_one_sample, .i_voltage_two_sample,
		.i_temperature_offset, .o_miso, .o_miso_oe_n, .o_clk_sample_ready_strobe, .o_dcdc_enable,
		.o_modulator_enable, .o_emission_control);
	aiso_host_model host (.i_miso(o_miso), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	always @(negedge i_clk) begin
		if (watch_dcdc && o_dcdc_enable !== 1'b1) dcdc_drop = 1'b1;
	end

	function automatic logic [15:0] crc72(input logic [71:0] d);
		logic [15:0] c;
		c = `AISO_CRC_INIT;
		for (int i = 71; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `AISO_CRC_POLY : 16'h0);
		return c;
	endfunction : crc72

	task automatic rd(input logic [4:0] a, input int nb);
		host.frame(a, 1'b1, 24'h0, nb, q);
	endtask : rd

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [23:0] dummy;
		host.frame(a, 1'b0, {16'h0, d}, 8, dummy);
	endtask : wr

	task automatic wait_ready();
		for (int i = 0; i < 10; i++) begin
			rd(`AISO_ADDR_PRIMARY, 8);
			if (q[0] === 1'b0) break;
		end
		`CHK(q[0], 1'b0)
	endtask : wait_ready

	task automatic t_defaults();
		`CHK(o_dcdc_enable, 1'b0)
		wait_ready();
		`CHK(o_dcdc_enable, 1'b1)
		`CHK(o_miso_oe_n, 1'b1)
		rd(`AISO_ADDR_SETUP, 8);   `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_EMI, 8);     `CHK(q[7:0], 8'hFF)
		`CHK(o_emission_control, 8'hFF)
		rd(`AISO_ADDR_KEY, 8);     `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_SYNC, 8);    `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_RSV_WIDE, 24); `CHK(q, 24'h000000)
		rd(`AISO_ADDR_RSV_HALF, 16); `CHK(q[15:0], 16'h0000)
		rd(`AISO_ADDR_SECONDARY, 8); `CHK(q[2:0], `AISO_VERSION)
		rd(`AISO_ADDR_CAPTURE, 16); `CHK(q[15:0], 16'h0000)
		rd(`AISO_ADDR_NOWRITE_A, 8); `CHK(q[7:0], 8'h00)
		rd(5'h14, 8);              `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_TEMP, 8);    `CHK(q[7:0], 8'hA5)
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_samples();
		logic [23:0] s [3];
		int n;
		s = '{24'h800001, 24'h7FFFFE, 24'h123456};
		@(negedge i_clk);
		i_current_sample = s[0];
		i_voltage_one_sample = s[1];
		i_voltage_two_sample = s[2];
		i_sample_valid = 1'b1;
		@(negedge i_clk);
		i_sample_valid = 1'b0;
		for (n = 0; n < 4 && o_clk_sample_ready_strobe !== 1'b0; n++) @(negedge i_clk);
		n = 0;
		while (o_clk_sample_ready_strobe === 1'b0 && n < 100) begin
			n++;
			@(negedge i_clk);
		end
		`CHK(n, 64)
		for (int i = 0; i < 3; i++) begin
			rd(5'(i), 24);
			`CHK(q, s[i])
		end
		wr(`AISO_ADDR_CURRENT, 8'h55);
		rd(`AISO_ADDR_CURRENT, 24); `CHK(q, s[0])
		rd(`AISO_ADDR_SMP_CRC, 16); `CHK(q[15:0], crc72({s[0], s[1], s[2]}))
		$display("test samples done");
	endtask : t_samples

	task automatic t_config();
		logic prev;
		int n;
		wr(`AISO_ADDR_EMI, 8'h5A);
		rd(`AISO_ADDR_EMI, 8);    `CHK(q[7:0], 8'h5A)
		`CHK(o_emission_control, 8'h5A)
		wr(`AISO_ADDR_SETUP, 8'h04);
		`CHK(o_dcdc_enable, 1'b0)
		`CHK(o_modulator_enable, 1'b0)
		rd(`AISO_ADDR_SETUP, 8);  `CHK(q[7:0], 8'h04)
		rd(`AISO_ADDR_EMI, 8);    `CHK(q[7:0], 8'h5A)
		for (int m = 0; m < 2; m++) begin
			wr(`AISO_ADDR_SETUP, m == 0 ? 8'h01 : 8'h00);
			n = 0;
			@(negedge i_clk);
			prev = o_clk_sample_ready_strobe;
			repeat (16) begin
				@(negedge i_clk);
				if (o_clk_sample_ready_strobe !== prev) n++;
				prev = o_clk_sample_ready_strobe;
			end
			// clock output toggles on every rising system clock edge
			`CHK(n, m == 0 ? 16 : 0)
		end
		`CHK(o_clk_sample_ready_strobe, 1'b1)
		`CHK(o_modulator_enable, 1'b1)
		$display("test config done");
	endtask : t_config

	task automatic t_counter();
		wr(`AISO_ADDR_CNT_HIGH, 8'h05);
		wr(`AISO_ADDR_CNT_LOW, 8'h00);
		wr(`AISO_ADDR_SYNC, `AISO_SYNC_COMMAND);
		rd(`AISO_ADDR_CNT_HIGH, 8); `CHK(q[3:0], 4'h5)
		rd(`AISO_ADDR_CAPTURE, 16); `CHK(q[15:8], 8'h05)
		$display("test counter done");
	endtask : t_counter

	task automatic t_lock();
		wr(`AISO_ADDR_KEY, `AISO_KEY_LOCK);
		rd(`AISO_ADDR_PRIMARY, 8); `CHK(q[2], 1'b1)
		wr(`AISO_ADDR_EMI, 8'h11);
		rd(`AISO_ADDR_EMI, 8);     `CHK(q[7:0], 8'h5A)
		wr(`AISO_ADDR_SETUP, 8'h01);
		rd(`AISO_ADDR_SETUP, 8);   `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_KEY, 8);     `CHK(q[7:0], 8'h00)
		wr(`AISO_ADDR_KEY, `AISO_KEY_UNLOCK);
		rd(`AISO_ADDR_PRIMARY, 8); `CHK(q[2], 1'b0)
		$display("test lock done");
	endtask : t_lock

	task automatic t_swreset();
		// protection was removed just before, as the host must do
		watch_dcdc = 1'b1;
		wr(`AISO_ADDR_SETUP, 8'h40);
		wait_ready();
		watch_dcdc = 1'b0;
		`CHK(dcdc_drop, 1'b0)
		rd(`AISO_ADDR_SETUP, 8); `CHK(q[7:0], 8'h00)
		rd(`AISO_ADDR_EMI, 8);   `CHK(q[7:0], 8'hFF)
		`CHK(o_emission_control, 8'hFF)
		$display("test soft reset done");
	endtask : t_swreset

	task automatic t_hwreset();
		wr(`AISO_ADDR_EMI, 8'h33);
		host.hw_reset();
		`CHK(o_dcdc_enable, 1'b0)
		`CHK(o_emission_control, 8'hFF)
		wait_ready();
		`CHK(o_dcdc_enable, 1'b1)
		rd(`AISO_ADDR_EMI, 8); `CHK(q[7:0], 8'hFF)
		$display("test hard reset done");
	endtask : t_hwreset

	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	initial begin
		failures = 0;
		total_checks = 0;
		watch_dcdc = 1'b0;
		dcdc_drop = 1'b0;
		i_resetn = 1'b0;
		i_sample_valid = 1'b0;
		i_current_sample = '0;
		i_voltage_one_sample = '0;
		i_voltage_two_sample = '0;
		i_temperature_offset = 8'hA5;
		repeat (20) @(negedge i_clk);
		i_resetn = 1'b1;
		t_defaults();
		t_samples();
		t_config();
		t_counter();
		t_lock();
		t_swreset();
		t_hwreset();
		wrap_up();
	end

	// about 47 frames of roughly 6 us each; generous margin
	initial begin
		#2000000;
		failures++;
		wrap_up();
	end
endmodule : aiso_top_tb
